// ===== src/grlc_ctrl.sv
// Overview of operation
// R1: local key cancels remote, restores local
// R2: local key clears remote lamp, restores display
// R3: local key ignored under local lockout
// R4: in remote, only local key works
// R5: remote only on listen address with ren
// R6: hold bus off during panel editing
// R7: release hold-off when display returns normal
// R8: talk and deliver data even in local
// R9: controller asserts ren, then addresses listener
// R10: ifc idles talker and listener, lamps off
// R11: controller holds ifc at least 100 us
// R12: llo locks local key; immediate in remote
// R13: ren false clears lockout and remote
// R14: controller sends llo with atn, unaddressed
// R15: addressed gtl leaves remote, keeps lockout
// R16: controller sends gtl after listen address
// R17: clear restores defaults, keeps address, drops drift
// R18: defaults: range 4, rate 3, bias 450
// R19: starred clear defaults come from setup 1
// R20: controller sends dcl with atn
// R21: primary address defaults to 15
// R22: listen with ren false flags no-remote error
// R23: sdc restores same defaults as dcl
// R24: sdc needs listen address; dcl always acts
`timescale 1ns/1ps
`default_nettype none
module grlc_ctrl
    import grlc_pkg::*;
(
    input  wire logic                     core_clk,      // core clock, 125 MHz
    input  wire logic                     rst_n,         // async reset, active low
    input  wire logic                     bus_ren,       // remote enable pin, true high
    input  wire logic                     bus_atn,       // attention pin, true high
    input  wire logic                     bus_ifc,       // interface clear pin, true high
    input  wire logic                     bus_dav,       // data valid pin, true high
    input  wire logic [7:0]               bus_dio,       // data lines, true high
    input  wire logic                     key_local,     // local key pin, pressed high
    input  wire logic [7:0]               key_panel,     // other panel keys, pressed high
    input  wire logic                     panel_busy,    // editing or buffer viewing
    input  wire logic                     msg_shown,     // bus message on display
    input  wire grlc_pkg::grlc_setup_type setup1,        // user saved setup 1
    input  wire logic                     cfg_wr,        // configuration write
    input  wire grlc_pkg::grlc_cfg_type   cfg_in,        // configuration value
    input  wire logic                     drift_set,     // drift correction performed
    input  wire logic                     addr_wr,       // primary address write
    input  wire logic [4:0]               addr_in,       // primary address value
    output logic                          bus_hold,      // hold off data handshake
    output logic                          data_take,     // data byte accepted pulse
    output logic [7:0]                    data_byte,     // accepted data byte
    output logic                          no_remote_err, // no-remote error pulse
    output logic                          talk_enable,   // talker active, may source
    output logic                          ind_talk,      // talk lamp
    output logic                          ind_listen,    // listen lamp
    output logic                          ind_remote,    // remote lamp
    output logic                          lockout,       // local key locked out
    output logic [7:0]                    key_press,     // gated panel key pulses
    output logic                          display_restore, // return display pulse
    output logic                          dev_clear,     // device clear pulse
    output grlc_pkg::grlc_cfg_type        cfg_q,         // live configuration
    output logic                          drift_correction, // drift constants valid
    output logic [4:0]                    addr_q         // primary address
);
    import grlc_pkg::*;

    logic [GRLC_BUS_W-1:0] bus_s;      // synchronised bus lines
    logic [GRLC_KEY_W-1:0] key_s;      // synchronised keys
    logic                  ren_s;      // remote enable, synchronised
    logic                  atn_s;      // attention, synchronised
    logic                  ifc_s;      // interface clear, synchronised
    logic                  dav_s;      // data valid, synchronised
    logic [7:0]            dio_s;      // data lines, synchronised
    logic                  dav_q;      // previous data valid
    logic [GRLC_KEY_W-1:0] key_q;      // previous key levels
    logic [GRLC_KEY_W-1:0] key_rise;   // key press edges
    logic                  dav_rise;   // new byte on the lines
    logic                  cmd_evt;    // interface message arrived
    logic                  data_evt;   // data byte arrived
    logic                  is_mla;     // my listen address
    logic                  is_mta;     // my talk address
    logic                  is_llo;     // local lockout message
    logic                  is_gtl_me;  // go to local, this device addressed
    logic                  clr_req;    // dcl, or sdc while addressed
    logic                  local_go;   // local key taken
    logic                  listen_q;   // listener active
    logic                  talk_q;     // talker active
    logic                  remote;     // any remote state
    logic                  pend_q;     // a held-off byte waits
    logic [7:0]            pend_byte_q; // the waiting byte
    grlc_rl_type           rl_q;       // remote/local state
    grlc_rl_type           rl_d;       // its next value

    // every bus and key pin passes two flops before any decode looks at it; panel_busy and msg_shown are used directly
    grlc_sync #(
        .WIDTH (GRLC_BUS_W)
    ) u_bus_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({bus_ren, bus_atn, bus_ifc, bus_dav, bus_dio}),
        .sync_out (bus_s)
    );

    // keys are mechanical and asynchronous, so they are synchronised too
    grlc_sync #(
        .WIDTH (GRLC_KEY_W)
    ) u_key_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({key_local, key_panel}),
        .sync_out (key_s)
    );

    assign {ren_s, atn_s, ifc_s, dav_s, dio_s} = bus_s;

    // edge memory for bus data valid and the keys
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dav_q <= 1'b0;
            key_q <= '0;
        end
        else
        begin
            dav_q <= dav_s;
            key_q <= key_s;
        end
    end

    // a byte is taken once, on the rising edge of data valid
    assign dav_rise = dav_s & ~dav_q;
    assign key_rise = key_s & ~key_q;
    assign cmd_evt  = dav_rise & atn_s;
    assign data_evt = dav_rise & ~atn_s;

    // message decode; addresses compare against the stored primary address
    assign is_mla    = cmd_evt && dio_s[GRLC_GRP_MSB:GRLC_GRP_LSB] == GRLC_GRP_LISTEN
                       && dio_s[GRLC_ADDR_MSB:0] == addr_q;
    assign is_mta    = cmd_evt && dio_s[GRLC_GRP_MSB:GRLC_GRP_LSB] == GRLC_GRP_TALK
                       && dio_s[GRLC_ADDR_MSB:0] == addr_q;
    assign is_llo    = cmd_evt && dio_s == GRLC_CMD_LLO;             // [R14]
    assign is_gtl_me = cmd_evt && dio_s == GRLC_CMD_GTL && listen_q; // [R15] [R16]
    // sdc counts only when addressed, dcl always; both give the same clear
    assign clr_req   = cmd_evt && (dio_s == GRLC_CMD_DCL
                       || (dio_s == GRLC_CMD_SDC && listen_q));      // [R20] [R23] [R24]

    assign remote   = (rl_q == GRLC_REMOTE) || (rl_q == GRLC_REMOTE_LOCK);
    // the local key only counts in plain remote; lockout swallows it
    assign local_go = key_rise[GRLC_KEY_W-1] && rl_q == GRLC_REMOTE;  // [R1] [R3]

    // listener and talker addressing; ifc holds both idle while asserted
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            listen_q <= 1'b0;
            talk_q   <= 1'b0;
        end
        else if (ifc_s)
        begin
            listen_q <= 1'b0; // [R10]
            talk_q   <= 1'b0; // [R10]
        end
        else if (is_mla)
        begin
            listen_q <= 1'b1;
            talk_q   <= 1'b0; // own listen address idles the talker
        end
        else if (is_mta)
        begin
            talk_q   <= 1'b1; // [R8]
            listen_q <= 1'b0; // own talk address idles the listener
        end
        else if (cmd_evt && dio_s == GRLC_CMD_UNL)
        begin
            listen_q <= 1'b0;
        end
        else if (cmd_evt && dio_s == GRLC_CMD_UNT)
        begin
            talk_q <= 1'b0;
        end
    end

    // remote/local next state
    always_comb
    begin
        rl_d = rl_q;
        if (!ren_s)
        begin
            rl_d = GRLC_LOCAL; // [R13]
        end
        else
        begin
            case (rl_q)
                GRLC_LOCAL:
                begin
                    // ren alone does nothing; the listen address does it [R5] [R9]
                    if (is_mla)
                        rl_d = GRLC_REMOTE;
                    else if (is_llo)
                        rl_d = GRLC_LOCAL_LOCK; // armed, bites once remote [R12]
                end
                GRLC_REMOTE:
                begin
                    if (is_llo)
                        rl_d = GRLC_REMOTE_LOCK; // immediate when remote [R12]
                    else if (local_go || is_gtl_me)
                        rl_d = GRLC_LOCAL;       // [R1] [R15]
                end
                GRLC_LOCAL_LOCK:
                begin
                    if (is_mla)
                        rl_d = GRLC_REMOTE_LOCK; // [R5] [R12]
                end
                GRLC_REMOTE_LOCK:
                begin
                    // gtl leaves remote but cannot cancel lockout
                    if (is_gtl_me)
                        rl_d = GRLC_LOCAL_LOCK;  // [R15]
                end
                default:
                begin
                    rl_d = GRLC_LOCAL;
                end
            endcase
        end
    end

    // remote/local state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rl_q <= GRLC_LOCAL;
        else
            rl_q <= rl_d;
    end

    // indicator lamps follow state one cycle later, from flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ind_remote  <= 1'b0;
            ind_talk    <= 1'b0;
            ind_listen  <= 1'b0;
            talk_enable <= 1'b0;
            lockout     <= 1'b0;
        end
        else
        begin
            ind_remote  <= remote;                       // [R2]
            ind_talk    <= talk_q;                       // [R10]
            ind_listen  <= listen_q;                     // [R10]
            talk_enable <= talk_q;                       // [R8]
            lockout     <= rl_q == GRLC_REMOTE_LOCK
                           || rl_q == GRLC_LOCAL_LOCK;   // [R3] [R13]
        end
    end

    // panel keys pass only in local; local key restores a bus message display
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_press       <= '0;
            display_restore <= 1'b0;
        end
        else
        begin
            key_press       <= remote ? 8'h00 : key_rise[GRLC_KEY_W-2:0]; // [R4]
            display_restore <= local_go && msg_shown;                     // [R2]
        end
    end

    // hold-off: a byte arriving while the panel is busy waits, the
    // handshake stalls, and it is delivered once the display is normal
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_q      <= 1'b0;
            pend_byte_q <= 8'h00;
        end
        else if (ifc_s || clr_req)
        begin
            pend_q <= 1'b0; // a clear drops the stalled byte
        end
        else if (data_evt && listen_q && ren_s && panel_busy)
        begin
            pend_q      <= 1'b1;                         // [R6]
            pend_byte_q <= dio_s;
        end
        else if (pend_q && !panel_busy)
        begin
            pend_q <= 1'b0;                              // [R7]
        end
    end

    assign bus_hold = pend_q; // handshake output comes straight from the pend_q flop [R6]

    // accepted data and the no-remote error
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_take     <= 1'b0;
            data_byte     <= 8'h00;
            no_remote_err <= 1'b0;
        end
        else
        begin
            data_take     <= 1'b0;
            no_remote_err <= 1'b0;
            if (pend_q && !panel_busy && !ifc_s && !clr_req)
            begin
                data_take <= 1'b1; // [R7]
                data_byte <= pend_byte_q;
            end
            else if (data_evt && listen_q && !ren_s)
            begin
                no_remote_err <= 1'b1; // byte refused [R22]
            end
            else if (data_evt && listen_q && !panel_busy && !pend_q)
            begin
                data_take <= 1'b1;
                data_byte <= dio_s;
            end
        end
    end

    // one-cycle clear pulse toward the rest of the instrument
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            dev_clear <= 1'b0;
        else
            dev_clear <= clr_req; // [R17] [R23] [R24]
    end

    // configuration store; the registered clear pulse drives it
    grlc_cfg u_cfg (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .dev_clear        (dev_clear),
        .setup1           (setup1),
        .cfg_wr           (cfg_wr),
        .cfg_in           (cfg_in),
        .drift_set        (drift_set),
        .addr_wr          (addr_wr),
        .addr_in          (addr_in),
        .cfg_q            (cfg_q),
        .drift_correction (drift_correction),
        .addr_q           (addr_q)
    );
endmodule : grlc_ctrl
`default_nettype wire

// ===== common/grlc_pkg.sv
// shared constants and carriers for the remote/local bus control block
package grlc_pkg;

    // interface message bytes seen with attention true (low five bits carry address)
    localparam logic [7:0] GRLC_CMD_GTL      = 8'h01; // go to local, addressed
    localparam logic [7:0] GRLC_CMD_SDC      = 8'h04; // selective device clear, addressed
    localparam logic [7:0] GRLC_CMD_LLO      = 8'h11; // local lockout, universal
    localparam logic [7:0] GRLC_CMD_DCL      = 8'h14; // device clear, universal
    localparam logic [7:0] GRLC_CMD_UNL      = 8'h3F; // unlisten
    localparam logic [7:0] GRLC_CMD_UNT      = 8'h5F; // untalk
    localparam logic [2:0] GRLC_GRP_LISTEN   = 3'h1;  // top bits 001: listen address group
    localparam logic [2:0] GRLC_GRP_TALK     = 3'h2;  // top bits 010: talk address group
    localparam int         GRLC_GRP_MSB      = 7;     // msb of the group field
    localparam int         GRLC_GRP_LSB      = 5;     // lsb of the group field
    localparam int         GRLC_ADDR_MSB     = 4;     // msb of the address field

    // power-up and clear defaults
    localparam logic [4:0]  GRLC_ADDR_DEFAULT  = 5'h0F;  // factory primary address 15
    localparam logic [3:0]  GRLC_RANGE_DEFAULT = 4'h4;   // range_default_code
    localparam logic [3:0]  GRLC_RATE_DEFAULT  = 4'h3;   // rate_default_code
    localparam logic [15:0] GRLC_BIAS_DEFAULT  = 16'h01C2; // bias count 450
    localparam logic [7:0]  GRLC_SRQ_DEFAULT   = 8'h00;  // service request disabled
    localparam logic [1:0]  GRLC_EOI_DEFAULT   = 2'h0;   // eoi and hold-off both enabled
    localparam logic [2:0]  GRLC_TERM_DEFAULT  = 3'h0;   // cr lf terminator

    // widths of the synchronised input groups
    localparam int GRLC_BUS_W = 12; // ren, atn, ifc, dav, eight data lines
    localparam int GRLC_KEY_W = 9;  // local key plus eight panel keys

    // remote/local states, one-hot
    typedef enum logic [3:0] {
        GRLC_LOCAL        = 4'b0001, // local, keys live
        GRLC_REMOTE       = 4'b0010, // remote, only local key live
        GRLC_LOCAL_LOCK   = 4'b0100, // local with lockout armed
        GRLC_REMOTE_LOCK  = 4'b1000  // remote with local key locked out
    } grlc_rl_type;

    // fields that the user saved setup 1 overrides on a clear
    typedef struct packed {
        logic [3:0]  range_code; // range setting
        logic [3:0]  rate_code;  // reading rate setting
        logic [15:0] bias_count; // bias step count
    } grlc_setup_type;

    // full operating configuration
    typedef struct packed {
        grlc_setup_type setup;       // starred fields
        logic [7:0]     srq_mask;    // service request mask
        logic [1:0]     eoi_holdoff; // eoi and hold-off mode
        logic [2:0]     term_code;   // terminator selection
    } grlc_cfg_type;

endpackage : grlc_pkg

// ===== src/grlc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a group of asynchronous levels
module grlc_sync #(
    parameter int WIDTH = 1 // number of levels
) (
    input  wire logic             core_clk, // core clock
    input  wire logic             rst_n,    // async reset, active low
    input  wire logic [WIDTH-1:0] async_in, // levels from pins
    output logic      [WIDTH-1:0] sync_out  // levels safe to use
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by the second

    // both stages clear to zero; pins are taken as inactive-low here
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : grlc_sync
`default_nettype wire

// ===== src/grlc_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// operating configuration, primary address and drift correction store
module grlc_cfg
    import grlc_pkg::*;
(
    input  wire logic                     core_clk,    // core clock
    input  wire logic                     rst_n,       // async reset, active low
    input  wire logic                     dev_clear,   // one-cycle clear request
    input  wire grlc_pkg::grlc_setup_type setup1,      // user saved setup 1
    input  wire logic                     cfg_wr,      // write new configuration
    input  wire grlc_pkg::grlc_cfg_type   cfg_in,      // configuration to write
    input  wire logic                     drift_set,   // drift correction done
    input  wire logic                     addr_wr,     // write primary address
    input  wire logic [4:0]               addr_in,     // new primary address
    output grlc_pkg::grlc_cfg_type        cfg_q,       // live configuration
    output logic                          drift_correction, // constants valid
    output logic [4:0]                    addr_q       // primary address
);
    import grlc_pkg::*;

    // configuration: clear takes starred fields from setup 1, others fixed
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q.setup.range_code <= GRLC_RANGE_DEFAULT; // [R18]
            cfg_q.setup.rate_code  <= GRLC_RATE_DEFAULT;  // [R18]
            cfg_q.setup.bias_count <= GRLC_BIAS_DEFAULT;  // [R18]
            cfg_q.srq_mask         <= GRLC_SRQ_DEFAULT;
            cfg_q.eoi_holdoff      <= GRLC_EOI_DEFAULT;
            cfg_q.term_code        <= GRLC_TERM_DEFAULT;
        end
        else if (dev_clear)
        begin
            cfg_q.setup       <= setup1;             // [R19]
            cfg_q.srq_mask    <= GRLC_SRQ_DEFAULT;   // [R18]
            cfg_q.eoi_holdoff <= GRLC_EOI_DEFAULT;   // [R18]
            cfg_q.term_code   <= GRLC_TERM_DEFAULT;  // [R17] [R18]
        end
        else if (cfg_wr)
        begin
            cfg_q <= cfg_in;
        end
    end

    // drift constants are lost on a clear; clear beats a same-cycle set
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            drift_correction <= 1'b0;
        else if (dev_clear)
            drift_correction <= 1'b0; // [R17]
        else if (drift_set)
            drift_correction <= 1'b1;
    end

    // primary address survives a clear; only reset or a write moves it
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            addr_q <= GRLC_ADDR_DEFAULT; // [R21]
        else if (addr_wr)
            addr_q <= addr_in;           // [R17]
    end
endmodule : grlc_cfg
`default_nettype wire

// ===== bench/grlc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks
module grlc_ctrl_props
    import grlc_pkg::*;
(
    input wire logic                     core_clk,   // clock
    input wire logic                     rst_n,      // reset
    input wire logic                     bus_ren,    // remote enable
    input wire logic                     bus_ifc,    // interface clear
    input wire logic                     panel_busy, // panel editing
    input wire grlc_pkg::grlc_setup_type setup1,     // saved setup
    input wire logic                     bus_hold,   // hold-off
    input wire logic                     data_take,  // byte taken
    input wire logic                     ind_talk,   // talk lamp
    input wire logic                     ind_remote, // remote lamp
    input wire logic                     lockout,    // lockout
    input wire logic [7:0]               key_press,  // gated keys
    input wire logic                     dev_clear,  // clear pulse
    input wire grlc_pkg::grlc_cfg_type   cfg_q,      // config
    input wire logic                     drift_correction, // drift valid
    input wire logic [4:0]               addr_q      // address
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // levels must outlast the two sync flops
    sequence s_ren_low;
        !bus_ren [*6];
    endsequence
    sequence s_cleared;
        cfg_q == {setup1, 13'h0000} && !drift_correction;
    endsequence
    a_reset_dflt: assert property ($rose(rst_n) |-> addr_q == 5'h0F
        && cfg_q.setup == {4'h4, 4'h3, 16'h01C2}) else $error("bad reset value");
    a_clear_dflt: assert property (dev_clear |=> s_cleared) else $error("bad clear");
    a_clear_addr: assert property (dev_clear |=> $stable(addr_q)) else $error("addr lost");
    a_hold_busy: assert property (bus_hold && !panel_busy |=> !bus_hold) else $error("hold");
    a_hold_no_take: assert property (bus_hold |-> !data_take) else $error("take");
    a_remote_keys: assert property (ind_remote && $past(ind_remote) |-> key_press == 8'h00)
        else $error("key in remote");
    a_ren_unlock: assert property (s_ren_low |-> !lockout && !ind_remote)
        else $error("ren low");
    a_ifc_idle: assert property (bus_ifc [*5] |-> !ind_talk) else $error("talk after ifc");
endmodule : grlc_ctrl_props
bind grlc_ctrl grlc_ctrl_props chk (.*);
`default_nettype wire

// ===== bench/grlc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus controller, lines true high
module grlc_bus_model (
    input  wire logic core_clk, // clock
    output logic       ren,      // remote enable
    output logic       atn,      // attention
    output logic       ifc,      // interface clear
    output logic       dav,      // data valid
    output logic [7:0] dio       // data lines
);
    initial {ren, atn, ifc, dav, dio} = 12'h000;
    // byte held four cycles; idle lines show its inverse
    task send(input logic a, input logic [7:0] d);
        @(negedge core_clk);
        atn = a;
        dio = d;
        dav = 1'b1;
        repeat (4) @(negedge core_clk);
        dav = 1'b0;
        dio = ~d;
        repeat (5) @(negedge core_clk);
    endtask : send
    // ifc pulse
    task clear_if(input int n);
        @(negedge core_clk);
        ifc = 1'b1;
        repeat (n) @(negedge core_clk);
        ifc = 1'b0;
    endtask : clear_if
endmodule : grlc_bus_model
`default_nettype wire

// ===== bench/gpib_remote_local_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// pins change on falling edges
module gpib_remote_local_control_test;
    import grlc_pkg::*;
    logic core_clk, rst_n, bus_ren, bus_atn, bus_ifc, bus_dav, key_local, panel_busy;
    logic msg_shown, drift_set, cfg_wr, addr_wr, bus_hold, data_take, no_remote_err;
    logic talk_enable, ind_talk, ind_listen, ind_remote, lockout, display_restore;
    logic dev_clear, drift_correction;
    logic [7:0] bus_dio, key_panel, data_byte, key_press, keys, d;
    logic [4:0] addr_in, addr_q;
    grlc_setup_type setup1;
    grlc_cfg_type cfg_in, cfg_q;
    int seed, checks, mismatches, n_take, n_err, n_clr, n_rst;
    grlc_ctrl uut (.*);
    grlc_bus_model ctl (.core_clk, .ren(bus_ren), .atn(bus_atn), .ifc(bus_ifc),
        .dav(bus_dav), .dio(bus_dio));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // pulse totals
    always @(posedge core_clk) begin
        n_take += data_take;
        n_err += no_remote_err;
        n_clr += dev_clear;
        n_rst += display_restore;
        keys |= key_press;
    end
    task check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    task cmd(input logic [7:0] c);
        ctl.send(1'b1, c);
    endtask : cmd
    task press(input logic [8:0] k);
        @(negedge core_clk) {key_local, key_panel} = k;
        idle(3);
        {key_local, key_panel} = 9'h000;
        idle(6);
    endtask : press
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        summarize();
    end
    initial begin
        {rst_n, key_local, key_panel, panel_busy, msg_shown, drift_set} = '0;
        {cfg_wr, cfg_in, addr_wr, addr_in, keys} = '0;
        seed = 99796;
        setup1 = 24'($random(seed));
        idle(4);
        rst_n = 1'b1;
        check("addr", addr_q, 32'h0F);
        check("setup", cfg_q.setup, {4'h4, 4'h3, 16'h01C2});
        // talk and refusal with ren false
        cmd(8'h4F);
        check("talk", talk_enable, 32'h1);
        cmd(8'h2F);
        ctl.send(1'b0, 8'h41);
        check("err", n_err, 32'h1);
        check("take", n_take, 32'h0);
        $display("test talk done");
        ctl.ren = 1'b1;
        idle(8);
        check("ren only", ind_remote, 32'h0);
        cmd(8'h2F);
        check("remote", ind_remote, 32'h1);
        press({1'b0, 8'($random(seed)) | 8'h01});
        check("keys", keys, 32'h0);
        d = 8'($random(seed));
        panel_busy = 1'b1;
        ctl.send(1'b0, d);
        check("hold", bus_hold, 32'h1);
        check("held", n_take, 32'h0);
        panel_busy = 1'b0;
        idle(3);
        check("taken", n_take, 32'h1);
        check("byte", data_byte, d);
        check("free", bus_hold, 32'h0);
        $display("test remote done");
        msg_shown = 1'b1;
        press(9'h100);
        msg_shown = 1'b0;
        check("local", ind_remote, 32'h0);
        check("restore", n_rst, 32'h1);
        press(9'h001);
        check("live key", keys, 32'h01);
        $display("test local key done");
        cmd(8'h2F);
        cmd(GRLC_CMD_LLO);
        check("lock", lockout, 32'h1);
        press(9'h100);
        check("locked", ind_remote, 32'h1);
        cmd(GRLC_CMD_GTL);
        check("gtl", {ind_remote, lockout}, 32'h1);
        ctl.ren = 1'b0;
        idle(8);
        check("unlock", lockout, 32'h0);
        $display("test lockout done");
        @(negedge core_clk) drift_set = 1'b1;
        @(negedge core_clk) drift_set = 1'b0;
        idle(2);
        check("drift", drift_correction, 32'h1);
        cmd(GRLC_CMD_UNL);
        cmd(GRLC_CMD_SDC);
        check("sdc unaddressed", n_clr, 32'h0);
        cmd(GRLC_CMD_DCL);
        check("dcl", n_clr, 32'h1);
        check("cleared", {cfg_q.setup, drift_correction, addr_q}, {setup1, 6'h0F});
        cmd(8'h2F);
        cmd(GRLC_CMD_SDC);
        check("sdc", n_clr, 32'h2);
        $display("test clear done");
        cmd(8'h4F);
        ctl.clear_if(12500);
        idle(4);
        check("ifc", {ind_talk, ind_listen}, 32'h0);
        $display("test ifc done");
        summarize();
    end
endmodule : gpib_remote_local_control_test
`default_nettype wire
